/* verilog/nco_frequency_control.sv */
`timescale 1ns/1ps
`include "nco_cfg.svh"
// What this block does
// - Increment is carrier plus deviation plus tuning, modulo 2^48.
// - Each frequency term can be forced to zero.
// - Accumulate phase; top 24 bits address sine.
// - Round 16-bit amplitude to 14 DAC bits.
// - Phase bit 47 weighs 180 degrees, half a cycle.
// - Two pins pick 0/90/180/270 degree offset.
// - Write-only byte port with address, strobe, enable.
// - Update copies all master registers to slaves together.
// - Writes accepted up to half the DDS rate.
// - Update held: output follows write after eleven cycles.
// - Update after write: output follows fourteen cycles later.
// - Gate pin adds deviation; fourteen-cycle latency.
// - Serial word held, then moved to DDS slave.
// - Serial load takes 8N+3 serial clocks plus fifteen.
// - Serial word left-aligned, lower bits zero.
// - Write to address 15 acts as update.
// - Reset: carrier quarter rate, deviation off, serial on.
module nco_frequency_control (
  input  wire logic        i_clk_sys,
  input  wire logic        i_rst,
  input  wire logic        i_wr_strobe,
  input  wire logic        i_wr_en_n,
  input  wire logic [3:0]  i_addr,
  input  wire logic [7:0]  i_data,
  input  wire logic        i_update_n,
  input  wire logic        i_deviation_gate,
  input  wire logic        i_phase_quad_sel_lo,
  input  wire logic        i_phase_quad_sel_hi,
  input  wire logic        i_ser_clk,
  input  wire logic        i_ser_data,
  input  wire logic        i_ser_sync,
  output var  logic [13:0] o_dac
);

  // ************************************************************
  // Declarations.
  // ************************************************************
  nco_pkg::host_pins_t   host_s1_reg, host_s2_reg, host_s3_reg;
  nco_pkg::ctl_pins_t    ctl_s1_reg, ctl_s2_reg, ctl_s3_reg, ctl_filt_reg;
  nco_pkg::ser_pins_t    ser_s1_reg, ser_s2_reg, ser_s3_reg;
  nco_pkg::ser_state_t   ser_state_reg;
  nco_pkg::freq_word_t   carrier_word, deviation_term_word, tuning_term_word;
  nco_pkg::freq_word_t   carrier_eff, dev_eff, tune_eff;
  nco_pkg::freq_word_t   freq_sum_reg, phase_acc_reg;
  logic [7:0]            master_reg [0:`REG_COUNT-1];
  logic [7:0]            slave_reg  [0:`REG_COUNT-1];
  logic                  wr_take;
  logic                  upd15_reg;
  logic                  copy_now;
  logic [`UPD_XTRA-1:0]  upd_dly_reg;
  logic [`GATE_XTRA-1:0] gate_dly_reg;
  logic [`SER_XTRA-1:0]  ser_dly_reg;
  logic                  ser_edge;
  logic                  ser_fire_reg;
  logic [2:0]            ser_bytes;
  logic [5:0]            ser_nbits;
  logic [5:0]            ser_shamt;
  logic [5:0]            ser_cnt_reg;
  logic [39:0]           ser_shift_reg;
  logic [39:0]           ser_hold_reg;
  logic [39:0]           tune_slave_reg;
  logic [23:0]           phase_addr_reg;
  logic [15:0]           amp;
  logic [16:0]           rnd_sum;
  logic [13:0]           rounded;
  logic [13:0]           dac_dly_reg [0:`OUT_XTRA-1];

  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (i_rst);

  // Power-on content of each master and slave byte.
  function automatic logic [7:0] reg_reset(input int idx);
    logic [7:0] val;
    val = 8'h00;
    if (idx == int'(`ADDR_CARRIER_TOP)) val = `CARRIER_TOP_RST;
    if (idx == int'(`ADDR_SER_CFG))     val = `SER_CFG_RST;
    if (idx == int'(`ADDR_CTL))         val = `CTL_RST;
    return val;
  endfunction

  // ************************************************************
  // Pin synchronisers.
  // ************************************************************
  // Every pin is asynchronous to the DDS clock, so each passes three stages.
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      host_s1_reg <= '0;
      host_s2_reg <= '0;
      host_s3_reg <= '0;
      ctl_s1_reg  <= `CTL_PINS_RST;
      ctl_s2_reg  <= `CTL_PINS_RST;
      ctl_s3_reg  <= `CTL_PINS_RST;
      ser_s1_reg  <= '0;
      ser_s2_reg  <= '0;
      ser_s3_reg  <= '0;
    end else begin
      host_s1_reg <= {i_wr_strobe, i_wr_en_n, i_addr, i_data};
      host_s2_reg <= host_s1_reg;
      host_s3_reg <= host_s2_reg;
      ctl_s1_reg  <= {i_update_n, i_deviation_gate, i_phase_quad_sel_hi,
                      i_phase_quad_sel_lo};
      ctl_s2_reg  <= ctl_s1_reg;
      ctl_s3_reg  <= ctl_s2_reg;
      ser_s1_reg  <= {i_ser_clk, i_ser_data, i_ser_sync};
      ser_s2_reg  <= ser_s1_reg;
      ser_s3_reg  <= ser_s2_reg;
    end
  end

  // Level pins change only once two stages agree, which rejects a runt.
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      ctl_filt_reg <= `CTL_PINS_RST;
    end else begin
      ctl_filt_reg <= (ctl_s3_reg & ~(ctl_s2_reg ^ ctl_s3_reg)) |
                      (ctl_filt_reg & (ctl_s2_reg ^ ctl_s3_reg));
    end
  end

  // ************************************************************
  // Parallel write port and master/slave registers.
  // ************************************************************
  // The strobe edge is taken from stages two and three without the agree
  // filter so that a one-cycle high, one-cycle low strobe still counts.
  assign wr_take = host_s2_reg.wr & ~host_s3_reg.wr & ~host_s2_reg.wr_en_n;

  // Update is active low; a write to the last address copies once as well.
  assign copy_now = ~upd_dly_reg[`UPD_XTRA-1] | upd15_reg;

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      upd15_reg   <= 1'b0;
      upd_dly_reg <= '1;
    end else begin
      upd15_reg   <= wr_take && (host_s2_reg.addr == `ADDR_UPDATE);
      upd_dly_reg <= {upd_dly_reg[`UPD_XTRA-2:0], ctl_filt_reg.update_n};
    end
  end

  for (genvar g = 0; g < `REG_COUNT; g++) begin : g_regs
    localparam logic [7:0] RST_VAL = reg_reset(g);

    // Host bytes land in the master copy only.
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
        master_reg[g] <= RST_VAL;
      end else if (wr_take && (host_s2_reg.addr == 4'(g))) begin
        master_reg[g] <= host_s2_reg.data;
      end
    end

    // All slave bytes move in one cycle so a word never changes piecemeal.
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
        slave_reg[g] <= RST_VAL;
      end else if (copy_now) begin
        slave_reg[g] <= master_reg[g];
      end
    end
  end

  // ************************************************************
  // Serial tuning link.
  // ************************************************************
  // Counts outside one to five fall back to the full 40-bit word.
  assign ser_bytes = (slave_reg[`ADDR_SER_CFG][`SER_BYTES_MSB:`SER_BYTES_LSB] == 3'h0 ||
                      slave_reg[`ADDR_SER_CFG][`SER_BYTES_MSB:`SER_BYTES_LSB] > `SER_BYTES_MAX)
                     ? `SER_BYTES_MAX
                     : slave_reg[`ADDR_SER_CFG][`SER_BYTES_MSB:`SER_BYTES_LSB];
  assign ser_nbits = {ser_bytes, 3'b000};
  assign ser_shamt = {3'(`SER_BYTES_MAX - ser_bytes), 3'b000};
  assign ser_edge  = ser_s2_reg.clk & ~ser_s3_reg.clk;

  // One serial clock carries sync, 8N carry data, two finish the move.
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      ser_state_reg <= nco_pkg::SER_IDLE;
      ser_cnt_reg   <= 6'h00;
      ser_shift_reg <= 40'h0;
      ser_hold_reg  <= 40'h0;
      ser_fire_reg  <= 1'b0;
    end else begin
      ser_fire_reg <= 1'b0;
      if (ser_edge) begin
        if (ser_s2_reg.sync) begin
          ser_state_reg <= nco_pkg::SER_SHIFT;
          ser_cnt_reg   <= 6'h00;
          ser_shift_reg <= 40'h0;
        end else begin
          case (ser_state_reg)
            nco_pkg::SER_SHIFT: begin
              ser_shift_reg <= {ser_shift_reg[38:0], ser_s2_reg.data};
              ser_cnt_reg   <= 6'(ser_cnt_reg + 6'h01);
              if (6'(ser_cnt_reg + 6'h01) == ser_nbits) begin
                ser_state_reg <= nco_pkg::SER_HOLD;
              end
            end
            nco_pkg::SER_HOLD: begin
              ser_hold_reg  <= ser_shift_reg << ser_shamt;
              ser_state_reg <= nco_pkg::SER_XFER;
            end
            nco_pkg::SER_XFER: begin
              ser_fire_reg  <= 1'b1;
              ser_state_reg <= nco_pkg::SER_IDLE;
            end
            default: begin
              ser_state_reg <= nco_pkg::SER_IDLE;
            end
          endcase
        end
      end
    end
  end

  // The delayed pulse lines the serial path up with its fifteen-cycle latency.
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      ser_dly_reg    <= '0;
      tune_slave_reg <= 40'h0;
    end else begin
      ser_dly_reg <= {ser_dly_reg[`SER_XTRA-2:0], ser_fire_reg};
      if (ser_dly_reg[`SER_XTRA-1]) begin
        tune_slave_reg <= ser_hold_reg;
      end
    end
  end

  // ************************************************************
  // Frequency sum, phase accumulator and quadrant offset.
  // ************************************************************
  assign carrier_word        = {slave_reg[5], slave_reg[4], slave_reg[3],
                                slave_reg[2], slave_reg[1], slave_reg[0]};
  assign deviation_term_word = {slave_reg[11], slave_reg[10], slave_reg[9],
                                slave_reg[8], slave_reg[7], slave_reg[6]};
  assign tuning_term_word    = {tune_slave_reg, 8'h00};

  // The software enables are kept so an unused serial term can be dropped.
  assign carrier_eff = slave_reg[`ADDR_CTL][`CTL_CARRIER_EN_BIT] ? carrier_word : '0;
  assign dev_eff     = gate_dly_reg[`GATE_XTRA-1] ? deviation_term_word : '0;
  assign tune_eff    = slave_reg[`ADDR_CTL][`CTL_SERIAL_EN_BIT] ? tuning_term_word : '0;

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      gate_dly_reg <= '0;
    end else begin
      gate_dly_reg <= {gate_dly_reg[`GATE_XTRA-2:0], ctl_filt_reg.gate};
    end
  end

  // Carry out of bit 47 is dropped, so the sum wraps like two's complement.
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      freq_sum_reg   <= '0;
      phase_acc_reg  <= '0;
      phase_addr_reg <= 24'h000000;
    end else begin
      freq_sum_reg   <= carrier_eff + dev_eff + tune_eff;
      phase_acc_reg  <= phase_acc_reg + freq_sum_reg;
      phase_addr_reg <= phase_acc_reg[47:24] + {ctl_filt_reg.quad, 22'h000000};
    end
  end

  sine_lookup u_sine (
    .i_clk_sys (i_clk_sys),
    .i_rst     (i_rst),
    .i_phase   (phase_addr_reg),
    .o_amp     (amp)
  );

  // ************************************************************
  // Rounding and DAC output.
  // ************************************************************
  // Round half up; the top two codes would wrap, so they saturate instead.
  assign rnd_sum = {amp[15], amp} + 17'h00002;
  assign rounded = (rnd_sum[16] != rnd_sum[15]) ? 14'h1fff : rnd_sum[15:2];

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      dac_dly_reg[0] <= 14'h0000;
      dac_dly_reg[1] <= 14'h0000;
      o_dac          <= 14'h0000;
    end else begin
      dac_dly_reg[0] <= rounded;
      dac_dly_reg[1] <= dac_dly_reg[0];
      o_dac          <= dac_dly_reg[`OUT_XTRA-1];
    end
  end

  // ************************************************************
  // Assertions and cover points.
  // ************************************************************
  a_sum_modulo: assert property (
    !$past(i_rst) |-> freq_sum_reg == 48'($past(carrier_eff) + $past(dev_eff) + $past(tune_eff)))
    else $error("frequency sum is not the wrapped sum of the three terms");

  a_dev_zeroed: assert property (
    !gate_dly_reg[`GATE_XTRA-1] |=> freq_sum_reg == 48'($past(carrier_eff) + $past(tune_eff)))
    else $error("deviation term leaked while the gate was off");

  a_gate_latency: assert property (
    $rose(ctl_filt_reg.gate) |-> ##`GATE_XTRA gate_dly_reg[`GATE_XTRA-1])
    else $error("gate did not reach the sum on time");

  a_accum_step: assert property (
    phase_acc_reg == 48'($past(phase_acc_reg) + $past(freq_sum_reg)))
    else $error("phase accumulator did not add the increment");

  a_quad_offset: assert property (
    phase_addr_reg == 24'($past(phase_acc_reg[47:24]) + {$past(ctl_filt_reg.quad), 22'h0}))
    else $error("quadrant offset not applied to sine address");

  a_master_write: assert property (
    wr_take |=> master_reg[$past(host_s2_reg.addr)] == $past(host_s2_reg.data))
    else $error("host byte not stored in master register");

  a_update_copy: assert property (
    copy_now |=> (slave_reg[0] == $past(master_reg[0])) &&
                 (slave_reg[13] == $past(master_reg[13])))
    else $error("update did not copy master to slave");

  a_update_delay: assert property (
    $fell(ctl_filt_reg.update_n) |-> ##2 copy_now)
    else $error("update did not reach the slave copy on time");

  a_reg15_update: assert property (
    (wr_take && host_s2_reg.addr == `ADDR_UPDATE) |=> copy_now)
    else $error("write to address 15 did not act as update");

  a_dac_round: assert property (
    ##3 o_dac == $past(rounded, 3))
    else $error("dac word is not the rounded amplitude");

  a_serial_align: assert property (
    (ser_state_reg == nco_pkg::SER_XFER) |->
      (ser_hold_reg & ~(40'hff_ffff_ffff << ser_shamt)) == 40'h0)
    else $error("serial word not left aligned");

  c_update_copy: cover property (wr_take ##[1:20] $fell(ctl_filt_reg.update_n));
  c_serial_load: cover property (ser_dly_reg[`SER_XTRA-1]);
  c_gate_toggle: cover property ($rose(gate_dly_reg[`GATE_XTRA-1]));
  c_quad_three:  cover property (ctl_filt_reg.quad == 2'b11 && freq_sum_reg != '0);

endmodule // nco_frequency_control

/* inc/nco_cfg.svh */
`ifndef NCO_CFG_SVH
`define NCO_CFG_SVH

// ************************************************************
// Master register map of the write-only control port.
// ************************************************************
`define ADDR_CARRIER_LO   4'h0
`define ADDR_CARRIER_TOP  4'h5
`define ADDR_DEV_LO       4'h6
`define ADDR_SER_CFG      4'hc
`define ADDR_CTL          4'hd
`define ADDR_UPDATE       4'hf
`define REG_COUNT         16

// ************************************************************
// Field positions.
// ************************************************************
`define CTL_CARRIER_EN_BIT  7
`define CTL_SERIAL_EN_BIT   6
`define SER_BYTES_MSB       2
`define SER_BYTES_LSB       0

// ************************************************************
// Reset values.
// ************************************************************
`define CARRIER_TOP_RST   8'h40
`define SER_CFG_RST       8'h05
`define CTL_RST           8'hc0
`define CTL_PINS_RST      4'h8
`define SER_BYTES_MAX     3'h5

// ************************************************************
// Latency balancing counts, in DDS clock cycles.
// ************************************************************
`define UPD_XTRA          2
`define GATE_XTRA         3
`define SER_XTRA          4
`define OUT_XTRA          2

// ************************************************************
// Sine shaping constant, 0.225 scaled by 2048.
// ************************************************************
`define CORR_MUL          9'h1cd

`endif

/* inc/nco_pkg.sv */
package nco_pkg;

  // ************************************************************
  // Pin groups carried through the synchronisers together.
  // ************************************************************
  typedef struct packed {
    logic       wr;
    logic       wr_en_n;
    logic [3:0] addr;
    logic [7:0] data;
  } host_pins_t;

  typedef struct packed {
    logic       update_n;
    logic       gate;
    logic [1:0] quad;
  } ctl_pins_t;

  typedef struct packed {
    logic clk;
    logic data;
    logic sync;
  } ser_pins_t;

  // Gray coded along idle, shift, hold, transfer.
  typedef enum logic [1:0] {
    SER_IDLE  = 2'b00,
    SER_SHIFT = 2'b01,
    SER_HOLD  = 2'b11,
    SER_XFER  = 2'b10
  } ser_state_t;

  typedef logic [47:0] freq_word_t;

endpackage

/* verilog/sine_lookup.sv */
`timescale 1ns/1ps
module sine_lookup (
  input  wire logic        i_clk_sys,
  input  wire logic        i_rst,
  input  wire logic [23:0] i_phase,
  output var  logic [15:0] o_amp
);

  // ************************************************************
  // Computed sine over one full cycle of the 24-bit address.
  // ************************************************************
  // A stored table of 2^24 words is out of reach, so the amplitude is
  // shaped by a corrected parabola; peak error stays near 0.1 percent.
  logic [23:0] x_comp;
  logic [46:0] par_prod;
  logic [15:0] par;
  logic [15:0] par_sat;
  logic [15:0] room;
  logic [31:0] sq_prod;
  logic [24:0] corr_prod;
  logic [15:0] mag;
  logic [15:0] amp_next;

  // Bit 23 selects the negative half cycle; the rest is the position in it.
  assign x_comp    = 24'h800000 - {1'b0, i_phase[22:0]};
  assign par_prod  = i_phase[22:0] * x_comp;
  assign par       = par_prod[44:29];
  assign par_sat   = par[15] ? 16'h7fff : par;
  assign room      = 16'h8000 - par_sat;
  assign sq_prod   = par_sat * room;
  assign corr_prod = sq_prod[30:15] * `CORR_MUL;
  assign mag       = par_sat - {2'b00, corr_prod[24:11]};
  assign amp_next  = i_phase[23] ? 16'(~mag + 16'h0001) : mag;

  // One register stage stands in for the table read.
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_amp <= 16'h0000;
    end else begin
      o_amp <= amp_next;
    end
  end

endmodule // sine_lookup

/* bench/host_model.sv */
`timescale 1ns/1ps
module host_model (
  input  wire logic       i_clk_sys,
  output var  logic       o_wr_strobe,
  output var  logic       o_wr_en_n,
  output var  logic [3:0] o_addr,
  output var  logic [7:0] o_data,
  output var  logic       o_ser_clk,
  output var  logic       o_ser_data,
  output var  logic       o_ser_sync
);
  // ************************************************************
  // Idle levels; the serial clock stands low outside frames.
  // ************************************************************
  initial begin
    o_wr_strobe = 1'b0;
    o_wr_en_n   = 1'b1;
    o_addr      = 4'h0;
    o_data      = 8'h00;
    o_ser_clk   = 1'b0;
    o_ser_data  = 1'b0;
    o_ser_sync  = 1'b0;
  end

  // One byte write; address and data settle three clocks before the strobe rises.
  task automatic wr(input logic [3:0] a, input logic [7:0] d, input logic we_n);
    @(negedge i_clk_sys);
    o_addr    = a;
    o_data    = d;
    o_wr_en_n = we_n;
    repeat (3) @(negedge i_clk_sys);
    o_wr_strobe = 1'b1;
    @(negedge i_clk_sys);
    o_wr_strobe = 1'b0;
    repeat (2) @(negedge i_clk_sys);
    o_wr_en_n = 1'b1;
    // The data bus is no longer qualified, so it shows the inverse of the last byte.
    o_data    = ~d;
  endtask

  // Two writes at half the DDS rate; the pins move together with the strobe.
  task automatic wr_pair(input logic [3:0] a0, input logic [7:0] d0,
                         input logic [3:0] a1, input logic [7:0] d1);
    @(negedge i_clk_sys);
    o_addr      = a0;
    o_data      = d0;
    o_wr_en_n   = 1'b0;
    o_wr_strobe = 1'b1;
    @(negedge i_clk_sys);
    o_wr_strobe = 1'b0;
    @(negedge i_clk_sys);
    o_addr      = a1;
    o_data      = d1;
    o_wr_strobe = 1'b1;
    @(negedge i_clk_sys);
    o_wr_strobe = 1'b0;
    @(negedge i_clk_sys);
    o_wr_en_n   = 1'b1;
    o_data      = ~d1;
  endtask

  // One frame: sync rise, 8n data rises MSB first, then two transfer rises.
  task automatic frame(input int n, input logic [39:0] w);
    @(negedge i_clk_sys);
    for (int i = -1; i < 8 * n + 2; i++) begin
      o_ser_sync = (i < 0);
      o_ser_data = (i >= 0 && i < 8 * n) ? w[39 - i] : ~o_ser_data;
      repeat (5) @(negedge i_clk_sys);
      o_ser_clk = 1'b1;
      repeat (5) @(negedge i_clk_sys);
      o_ser_clk = 1'b0;
    end
    o_ser_sync = 1'b0;
  endtask
endmodule // host_model

/* bench/nco_frequency_control_tb.sv */
`timescale 1ns/1ps
`include "nco_cfg.svh"
module nco_frequency_control_tb;
  logic        clk_sys = 1'b0;
  logic        rst;
  logic        wr_strobe;
  logic        wr_en_n;
  logic [3:0]  addr;
  logic [7:0]  data;
  logic        update_n;
  logic        gate;
  logic        q_lo;
  logic        q_hi;
  logic        ser_clk;
  logic        ser_data;
  logic        ser_sync;
  logic [13:0] dac;
  int          fails = 0;
  int          samples_checked = 0;

  always #4 clk_sys = ~clk_sys;

  nco_frequency_control u_nco_frequency_control (
    .i_clk_sys(clk_sys), .i_rst(rst), .i_wr_strobe(wr_strobe), .i_wr_en_n(wr_en_n),
    .i_addr(addr), .i_data(data), .i_update_n(update_n), .i_deviation_gate(gate),
    .i_phase_quad_sel_lo(q_lo), .i_phase_quad_sel_hi(q_hi), .i_ser_clk(ser_clk),
    .i_ser_data(ser_data), .i_ser_sync(ser_sync), .o_dac(dac)
  );

  host_model u_host_model (
    .i_clk_sys(clk_sys), .o_wr_strobe(wr_strobe), .o_wr_en_n(wr_en_n), .o_addr(addr),
    .o_data(data), .o_ser_clk(ser_clk), .o_ser_data(ser_data), .o_ser_sync(ser_sync)
  );

  // ************************************************************
  // Helpers. A frozen phase is always a multiple of 90 degrees.
  // ************************************************************
  function automatic logic [13:0] quad_val(input int k);
    case (k % 4)
      1: return 14'h1fff;
      3: return 14'h2001;
      default: return 14'h0000;
    endcase
  endfunction

  // The sine shaping is approximate, so a few codes of slack are allowed.
  function automatic bit near(input logic [13:0] v, input logic [13:0] e);
    int d;
    d = $signed(v) - $signed(e);
    return (^v !== 1'bx) && d <= 8 && d >= -8;
  endfunction

  task automatic check(input bit ok, input string msg);
    samples_checked++;
    if (!ok) begin
      fails++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask

  // Four samples must walk the sine forward by 90 degrees from any start.
  task automatic rot_check(input logic [13:0] s [4], input string msg);
    bit ok;
    bit all;
    ok = 1'b0;
    for (int k = 0; k < 4; k++) begin
      all = 1'b1;
      for (int i = 0; i < 4; i++) all &= near(s[i], quad_val(k + i));
      ok |= all;
    end
    check(ok, msg);
  endtask

  task automatic hold_check(input int n, input string msg);
    logic [13:0] v;
    bit          ok;
    v  = dac;
    ok = (^v !== 1'bx);
    repeat (n) begin
      @(negedge clk_sys);
      ok &= (dac === v);
    end
    check(ok, msg);
  endtask

  // Counts falling edges from now until the output leaves its frozen value.
  task automatic lat_check(input int lo, input int hi, input string msg);
    logic [13:0] v;
    int          n;
    v = dac;
    n = 0;
    while (dac === v && n < 40) begin
      @(negedge clk_sys);
      n++;
    end
    check(n >= lo && n <= hi, msg);
  endtask

  task automatic settle_ctl(input logic [7:0] c);
    u_host_model.wr(`ADDR_CTL, c, 1'b0);
    repeat (20) @(negedge clk_sys);
  endtask

  // ************************************************************
  // Scenarios.
  // ************************************************************
  task automatic t_reset();
    logic [13:0] s [4];
    repeat (16) @(negedge clk_sys);
    for (int i = 0; i < 4; i++) begin
      s[i] = dac;
      @(negedge clk_sys);
    end
    rot_check(s, "reset output is not a quarter-rate sine");
  endtask

  task automatic t_freeze();
    u_host_model.wr(`ADDR_CTL, 8'h00, 1'b0);
    u_host_model.wr(`ADDR_UPDATE, 8'h00, 1'b0);
    repeat (20) @(negedge clk_sys);
    hold_check(16, "carrier term not zeroed");
    u_host_model.wr(`ADDR_CTL, 8'h80, 1'b1);
    u_host_model.wr(`ADDR_UPDATE, 8'h00, 1'b0);
    repeat (20) @(negedge clk_sys);
    hold_check(16, "write with enable high took effect");
  endtask

  task automatic t_quad();
    logic [13:0] s [4];
    for (int q = 0; q < 4; q++) begin
      q_lo = q[0];
      q_hi = q[1];
      repeat (10) @(negedge clk_sys);
      s[q] = dac;
    end
    rot_check(s, "quadrant offsets wrong");
    q_lo = 1'b0;
    q_hi = 1'b0;
    repeat (10) @(negedge clk_sys);
  endtask

  task automatic t_update();
    u_host_model.wr(`ADDR_CTL, 8'h80, 1'b0);
    hold_check(20, "master reached slave without update");
    update_n = 1'b0;
    lat_check(14, 14, "late update latency");
    settle_ctl(8'h00);
    fork
      u_host_model.wr(`ADDR_CTL, 8'h80, 1'b0);
      begin
        @(posedge wr_strobe);
        lat_check(11, 11, "held update latency");
      end
    join
    settle_ctl(8'h00);
  endtask

  // A three-quarter carrier walks backward, so samples are stored in reverse.
  task automatic t_fast();
    logic [13:0] s [4];
    u_host_model.wr_pair(`ADDR_CARRIER_TOP, 8'hc0, `ADDR_CTL, 8'h80);
    repeat (20) @(negedge clk_sys);
    for (int i = 3; i >= 0; i--) begin
      s[i] = dac;
      @(negedge clk_sys);
    end
    rot_check(s, "half-rate writes lost");
    u_host_model.wr(`ADDR_CARRIER_TOP, 8'h40, 1'b0);
    settle_ctl(8'h00);
  endtask

  task automatic t_gate();
    u_host_model.wr(4'hb, 8'h40, 1'b0);
    hold_check(20, "deviation added while gate low");
    gate = 1'b1;
    lat_check(14, 14, "gate latency");
    gate = 1'b0;
    repeat (20) @(negedge clk_sys);
    // A quarter carrier plus minus a quarter deviation wraps to zero.
    u_host_model.wr(4'hb, 8'hc0, 1'b0);
    u_host_model.wr(`ADDR_CTL, 8'h80, 1'b0);
    gate = 1'b1;
    repeat (20) @(negedge clk_sys);
    hold_check(20, "sum not kept to 48 bits");
    gate = 1'b0;
    settle_ctl(8'h00);
  endtask

  task automatic t_serial();
    logic [13:0] s [4];
    u_host_model.wr(`ADDR_SER_CFG, 8'h01, 1'b0);
    settle_ctl(8'h40);
    fork
      u_host_model.frame(1, 40'h40_0000_0000);
      begin
        repeat (11) @(posedge ser_clk);
        lat_check(13, 15, "serial word latency or alignment");
      end
    join
    // Only a word aligned to the top bits gives a quarter-rate walk.
    for (int i = 0; i < 4; i++) begin
      s[i] = dac;
      @(negedge clk_sys);
    end
    rot_check(s, "serial word not aligned to the top");
    settle_ctl(8'h00);
  endtask

  task automatic wrap_up();
    $display("checks %0d, mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // ************************************************************
  // Main sequence and watchdog.
  // ************************************************************
  initial begin
    rst      = 1'b1;
    update_n = 1'b1;
    gate     = 1'b0;
    q_lo     = 1'b0;
    q_hi     = 1'b0;
    repeat (20) @(negedge clk_sys);
    rst = 1'b0;
    t_reset();
    t_freeze();
    t_quad();
    t_update();
    t_fast();
    t_gate();
    t_serial();
    wrap_up();
  end

  // The scenarios need some 700 cycles; this bound leaves ample margin.
  initial begin
    #100000;
    fails++;
    $display("mismatch at %0t: watchdog expired", $time);
    wrap_up();
  end
endmodule // nco_frequency_control_tb
